// file: include/aoi_defs.vh
`ifndef AOI_DEFS_VH
`define AOI_DEFS_VH
// sample word geometry
`define AOI_W        12
`define AOI_MSB      11
`define AOI_ACC_W    13
`define AOI_RES_W    14
`define AOI_STAGES   9
`define AOI_TAIL     6
// analog scale in lsb units, residue domain
`define AOI_VREF     14'sh0800
`define AOI_QTR      14'sh0200
`define AOI_FS_HI    14'sh07ff
`define AOI_FS_LO    14'sh3800
`define AOI_FLASH_SH 9
`define AOI_FLASH_MX 14'sh0007
`define AOI_SAT      12'hfff
// timing
`define AOI_CLK_NS    100
`define AOI_SETTLE_MS 10
// settle span in converter-side system cycles: 10 ms of 100 ns clocks
`define AOI_SETTLE_CYC 17'd100000
`define AOI_SET_W     17
`define AOI_PER_W     10
// register byte offsets
`define AOI_A_TRIM   8'h00
`define AOI_A_STAT   8'h04
`define AOI_A_ISTAT  8'h08
`define AOI_A_IMASK  8'h0c
`define AOI_A_LAST   8'h10
// field layout
`define AOI_TRIM_W   8
`define AOI_IRQ_W    2
`define AOI_IRQ_OVR  0
`define AOI_IRQ_RDY  1
`endif

// file: src/aoi_stage.v
`timescale 1ns/1ps
`default_nettype none
`include "aoi_defs.vh"
// one 1.5-bit pipeline stage: resolves a partial code and passes the
// doubled residue on; redundancy lets later stages absorb comparator offset
module aoi_stage
#(
  parameter IDX = 1
)
(
  input  wire                    sys_clk,
  input  wire                    reset_n,
  input  wire                    adv,
  input  wire                    vldIn,
  input  wire                    ovrIn,
  input  wire [`AOI_RES_W-1:0]   resIn,
  input  wire [`AOI_ACC_W-1:0]   accIn,
  input  wire [`AOI_RES_W-1:0]   trim,
  output reg                     vldOut_r,
  output reg                     ovrOut_r,
  output reg  [`AOI_RES_W-1:0]   resOut_r,
  output reg  [`AOI_ACC_W-1:0]   accOut_r
);
  wire signed [`AOI_RES_W-1:0] v     = resIn;        // residue from previous stage
  wire signed [`AOI_RES_W-1:0] trimS = trim;         // common comparator offset
  wire signed [`AOI_RES_W-1:0] thHi  = trimS + `AOI_QTR;
  wire signed [`AOI_RES_W-1:0] thLo  = trimS - `AOI_QTR;
  wire                         hi    = v > thHi;    // upper comparator
  wire                         lo    = v < thLo;    // lower comparator
  wire signed [`AOI_RES_W-1:0] dbl   = v <<< 1;      // residue gain of two
  // amplified residue error handed to the next stage
  wire signed [`AOI_RES_W-1:0] res   = hi ? dbl - `AOI_VREF :
                                       (lo ? dbl + `AOI_VREF : dbl);
  wire [`AOI_ACC_W-1:0] code = hi ? 13'h0002 : (lo ? 13'h0000 : 13'h0001);
  // overlapping weights add the partial code: offsets cancel out here
  wire [`AOI_ACC_W-1:0] acc  = accIn + (code << (`AOI_MSB - IDX));

  // advance one position on every half cycle of the converter clock
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      vldOut_r <= 1'b0;
      ovrOut_r <= 1'b0;
      resOut_r <= {`AOI_RES_W{1'b0}};
      accOut_r <= {`AOI_ACC_W{1'b0}};
    end
    else if (adv)
    begin
      vldOut_r <= vldIn;
      ovrOut_r <= ovrIn;
      resOut_r <= res;
      accOut_r <= acc;
    end
  end
endmodule
`default_nettype wire

// file: src/aoi_out_if.v
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "aoi_defs.vh"
// Operation
// - clock kind pin picks single or differential
// - overrange flag high beyond full scale
// - twelve-bit word, bit 11 most significant
// - valid clock follows input, duty corrected
// - power-down pin high stops conversion
// - format pin: low two's complement, high gray
// - word appears 8.5 input cycles after sampling
// - sample moves one stage per half cycle
// - ten stages, residue passed stage to stage
// - error correction removes comparator offsets
// - equalizer pin enables duty correction
// - sample taken on falling input clock edge
// - reference settles 10 ms after power-up/wake
module aoi_out_if
#(
  parameter [`AOI_SET_W-1:0] SETTLE_CYC = `AOI_SETTLE_CYC
)
(
  input  wire                   sys_clk,
  input  wire                   reset_n,
  input  wire                   clockInPos,
  input  wire                   clockInNeg,
  input  wire                   clockKindSelect,
  input  wire                   formatSelect,
  input  wire                   powerdownPin,
  input  wire                   dutyEqualizerEnable,
  input  wire [`AOI_RES_W-1:0]  heldInput,
  output reg  [`AOI_W-1:0]      sampleWord_r,
  output reg                    overrangeFlag_r,
  output reg                    sampleValidClock_r,
  output reg                    refSettling_r,
  output reg                    irq_r,
  input  wire                   hsel,
  input  wire [31:0]            haddr,
  input  wire [1:0]             htrans,
  input  wire                   hwrite,
  input  wire [2:0]             hsize,
  input  wire [31:0]            hwdata,
  input  wire                   hready,
  output reg                    hreadyout,
  output reg                    hresp,
  output reg  [31:0]            hrdata
);
  // two-flop synchronisers for every pin
  reg  [5:0]             pinMeta_r;   // first flop, read only by pinSync_r
  reg  [5:0]             pinSync_r;   // {dce, pd, fmt, kind, neg, pos}
  reg  [`AOI_RES_W-1:0]  vinMeta_r;   // held analog value, first flop
  reg  [`AOI_RES_W-1:0]  vinSync_r;   // held analog value, second flop
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pinMeta_r <= 6'h00;
      pinSync_r <= 6'h00;
      vinMeta_r <= {`AOI_RES_W{1'b0}};
      vinSync_r <= {`AOI_RES_W{1'b0}};
    end
    else
    begin
      pinMeta_r <= {dutyEqualizerEnable, powerdownPin, formatSelect,
                    clockKindSelect, clockInNeg, clockInPos};
      pinSync_r <= pinMeta_r;
      vinMeta_r <= heldInput;
      vinSync_r <= vinMeta_r;
    end
  end
  wire dceOn  = pinSync_r[5];
  wire pdOn   = pinSync_r[4];
  wire grayOn = pinSync_r[3];
  wire diffOn = pinSync_r[2];

  // converter clock level: differential compares the pair
  wire clkLvl = diffOn ? (pinSync_r[0] & ~pinSync_r[1]) : pinSync_r[0];
  reg  clkLvl_r;                      // previous level for edge detect
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      clkLvl_r <= 1'b0;
    else
      clkLvl_r <= clkLvl;
  end
  wire fallEdge = clkLvl_r & ~clkLvl & ~pdOn;
  wire riseEdge = ~clkLvl_r & clkLvl & ~pdOn;
  wire halfStep = fallEdge | riseEdge; // both edges move the pipeline

  // entry: capture on the falling edge, bubble on the rising edge
  wire signed [`AOI_RES_W-1:0] vinS = vinSync_r;
  wire vinOvr = (vinS > `AOI_FS_HI) | (vinS < `AOI_FS_LO);
  reg                    entVld_r;    // sample present in entry
  reg                    entOvr_r;    // out-of-range for this sample
  reg  [`AOI_RES_W-1:0]  entRes_r;    // clamped input residue
  always @(posedge sys_clk)
  begin
    if (!reset_n || pdOn)
    begin
      entVld_r <= 1'b0;
      entOvr_r <= 1'b0;
      entRes_r <= {`AOI_RES_W{1'b0}};
    end
    else if (halfStep)
    begin
      entVld_r <= fallEdge;
      entOvr_r <= vinOvr;
      // clamp so the stages saturate instead of wrapping
      if (vinS > `AOI_FS_HI)
        entRes_r <= `AOI_FS_HI;
      else if (vinS < `AOI_FS_LO)
        entRes_r <= `AOI_FS_LO;
      else
        entRes_r <= vinS;
    end
  end

  // comparator trim register, sign extended into the residue domain
  reg  [`AOI_TRIM_W-1:0] trim_r;
  wire [`AOI_RES_W-1:0]  trimX = {{(`AOI_RES_W-`AOI_TRIM_W){trim_r[`AOI_TRIM_W-1]}}, trim_r};

  // nine 1.5-bit stages; the flash below is the tenth
  wire                   stVld [0:`AOI_STAGES];
  wire                   stOvr [0:`AOI_STAGES];
  wire [`AOI_RES_W-1:0]  stRes [0:`AOI_STAGES];
  wire [`AOI_ACC_W-1:0]  stAcc [0:`AOI_STAGES];
  assign stVld[0] = entVld_r;
  assign stOvr[0] = entOvr_r;
  assign stRes[0] = entRes_r;
  assign stAcc[0] = {`AOI_ACC_W{1'b0}};
  genvar g;
  generate
    for (g = 1; g <= `AOI_STAGES; g = g + 1)
    begin : gStage
      aoi_stage #(.IDX(g)) uStage
      (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n & ~pdOn),
        .adv      (halfStep),
        .vldIn    (stVld[g-1]),
        .ovrIn    (stOvr[g-1]),
        .resIn    (stRes[g-1]),
        .accIn    (stAcc[g-1]),
        .trim     (trimX),
        .vldOut_r (stVld[g]),
        .ovrOut_r (stOvr[g]),
        .resOut_r (stRes[g]),
        .accOut_r (stAcc[g])
      );
    end
  endgenerate

  // last stage: 3-bit flash on the final residue, then correction sum
  wire signed [`AOI_RES_W-1:0] lastRes = stRes[`AOI_STAGES];
  wire signed [`AOI_RES_W-1:0] flashRaw = (lastRes + `AOI_VREF) >>> `AOI_FLASH_SH;
  wire [2:0] flash = flashRaw[`AOI_RES_W-1] ? 3'h0 :
                     (flashRaw > `AOI_FLASH_MX ? 3'h7 : flashRaw[2:0]);
  wire [`AOI_ACC_W-1:0] obSum = stAcc[`AOI_STAGES] + {10'h000, flash};
  // saturate at the top code so the word never wraps
  wire [`AOI_W-1:0] offBin = obSum[`AOI_W] ? `AOI_SAT : obSum[`AOI_W-1:0];
  wire [`AOI_W-1:0] twosWord = {~offBin[`AOI_MSB], offBin[`AOI_MSB-1:0]};
  wire [`AOI_W-1:0] grayWord = offBin ^ (offBin >> 1);
  wire [`AOI_W-1:0] codedWord = grayOn ? grayWord : twosWord;

  // tail delay brings the total to seventeen half steps
  reg                    tailVld_r [0:`AOI_TAIL];
  reg  [`AOI_W:0]        tailDat_r [0:`AOI_TAIL]; // {overrange, word}
  always @(posedge sys_clk)
  begin
    if (!reset_n || pdOn)
    begin
      tailVld_r[0] <= 1'b0;
      tailDat_r[0] <= {(`AOI_W+1){1'b0}};
    end
    else if (halfStep)
    begin
      tailVld_r[0] <= stVld[`AOI_STAGES];
      tailDat_r[0] <= {stOvr[`AOI_STAGES], codedWord};
    end
  end
  genvar t;
  generate
    for (t = 1; t <= `AOI_TAIL; t = t + 1)
    begin : gTail
      always @(posedge sys_clk)
      begin
        if (!reset_n || pdOn)
        begin
          tailVld_r[t] <= 1'b0;
          tailDat_r[t] <= {(`AOI_W+1){1'b0}};
        end
        else if (halfStep)
        begin
          tailVld_r[t] <= tailVld_r[t-1];
          tailDat_r[t] <= tailDat_r[t-1];
        end
      end
    end
  endgenerate
  wire outStep = halfStep & tailVld_r[`AOI_TAIL];

  // output pins: word and flag change together on the rising edge
  always @(posedge sys_clk)
  begin
    if (!reset_n || pdOn)
    begin
      sampleWord_r    <= {`AOI_W{1'b0}};
      overrangeFlag_r <= 1'b0;
    end
    else if (outStep)
    begin
      sampleWord_r    <= tailDat_r[`AOI_TAIL][`AOI_MSB:0];
      overrangeFlag_r <= tailDat_r[`AOI_TAIL][`AOI_W];
    end
  end

  // period of the input clock measured between falling edges
  reg  [`AOI_PER_W-1:0] perCnt_r;     // cycles since last falling edge
  reg  [`AOI_PER_W-1:0] halfPer_r;    // half of the last full period
  reg  [`AOI_PER_W-1:0] davCnt_r;     // countdown to valid clock high
  always @(posedge sys_clk)
  begin
    if (!reset_n || pdOn)
    begin
      perCnt_r  <= {`AOI_PER_W{1'b0}};
      halfPer_r <= {`AOI_PER_W{1'b0}};
    end
    else if (fallEdge)
    begin
      perCnt_r  <= {{(`AOI_PER_W-1){1'b0}}, 1'b1};
      halfPer_r <= perCnt_r >> 1;
    end
    else if (~&perCnt_r)
      perCnt_r <= perCnt_r + 1'b1; // saturate on a stopped clock
  end

  // valid clock: low on the data change, high half a period later;
  // without the equalizer it simply follows the raw input duty
  always @(posedge sys_clk)
  begin
    if (!reset_n || pdOn)
    begin
      sampleValidClock_r <= 1'b0;
      davCnt_r           <= {`AOI_PER_W{1'b0}};
    end
    else if (riseEdge)
    begin
      sampleValidClock_r <= 1'b0;
      davCnt_r           <= dceOn ? halfPer_r : {`AOI_PER_W{1'b0}};
    end
    else if (!dceOn)
    begin
      if (fallEdge)
        sampleValidClock_r <= 1'b1;
    end
    else if (davCnt_r != {`AOI_PER_W{1'b0}})
    begin
      davCnt_r <= davCnt_r - 1'b1;
      if (davCnt_r == {{(`AOI_PER_W-1){1'b0}}, 1'b1})
        sampleValidClock_r <= 1'b1;
    end
  end

  // reference settling after reset release and after wake-up
  reg  [`AOI_SET_W-1:0] settleCnt_r;
  always @(posedge sys_clk)
  begin
    if (!reset_n || pdOn)
      settleCnt_r <= SETTLE_CYC;
    else if (settleCnt_r != {`AOI_SET_W{1'b0}})
      settleCnt_r <= settleCnt_r - 1'b1;
  end
  wire settleDone = refSettling_r & ~pdOn & (settleCnt_r == {`AOI_SET_W{1'b0}});
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      refSettling_r <= 1'b1;
    else
      refSettling_r <= pdOn | (settleCnt_r != {`AOI_SET_W{1'b0}});
  end

  // ahb-lite slave, zero wait state, always okay
  reg        wrPend_r;                // write data phase pending
  reg  [7:0] wrAddr_r;                // latched low address of the write
  reg  [`AOI_IRQ_W-1:0] istat_r;      // sticky event bits
  reg  [`AOI_IRQ_W-1:0] imask_r;      // interrupt enables
  wire       acc   = hsel & htrans[1] & hready;
  wire [7:0] rAddr = haddr[7:0];
  wire [`AOI_IRQ_W-1:0] evt;
  assign evt[`AOI_IRQ_OVR] = outStep & tailDat_r[`AOI_TAIL][`AOI_W];
  assign evt[`AOI_IRQ_RDY] = settleDone;
  wire [`AOI_IRQ_W-1:0] clr = (wrPend_r && wrAddr_r == `AOI_A_ISTAT) ?
                              hwdata[`AOI_IRQ_W-1:0] : {`AOI_IRQ_W{1'b0}};
  // a new event beats a clear in the same cycle
  wire [`AOI_IRQ_W-1:0] istatNxt = (istat_r & ~clr) | evt;

  // register writes land in the data phase
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      trim_r   <= {`AOI_TRIM_W{1'b0}};
      imask_r  <= {`AOI_IRQ_W{1'b0}};
      istat_r  <= {`AOI_IRQ_W{1'b0}};
      irq_r    <= 1'b0;
    end
    else
    begin
      wrPend_r <= acc & hwrite;
      wrAddr_r <= rAddr;
      istat_r  <= istatNxt;
      irq_r    <= |(istatNxt & imask_r);
      if (wrPend_r && wrAddr_r == `AOI_A_TRIM)
        trim_r <= hwdata[`AOI_TRIM_W-1:0];
      if (wrPend_r && wrAddr_r == `AOI_A_IMASK)
        imask_r <= hwdata[`AOI_IRQ_W-1:0];
    end
  end

  // read data registered at the address phase, valid in the data phase
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc && !hwrite)
      begin
        case (rAddr)
          `AOI_A_TRIM:  hrdata <= {24'h000000, trim_r};
          `AOI_A_STAT:  hrdata <= {27'h0000000, refSettling_r, dceOn, pdOn,
                                   grayOn, diffOn};
          `AOI_A_ISTAT: hrdata <= {30'h00000000, istat_r};
          `AOI_A_IMASK: hrdata <= {30'h00000000, imask_r};
          `AOI_A_LAST:  hrdata <= {19'h00000, overrangeFlag_r, sampleWord_r};
          default:      hrdata <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/aoi_out_if_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port-side checks on the converter output block
module aoi_out_if_checker
#(
  parameter int SETTLE_CYC = 100000
)
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        powerdownPin,
  input wire logic [11:0] sampleWord_r,
  input wire logic        overrangeFlag_r,
  input wire logic        sampleValidClock_r,
  input wire logic        refSettling_r,
  input wire logic        irq_r,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  logic [31:0] settleCnt_r; // awake cycles spent settling
  logic        maskWr_r;    // mask write now in its data phase
  wire         take = hsel && htrans[1] && hready;
  // a counter bounds the settle span, far too long for a delay range
  always_ff @(posedge sys_clk)
  begin
    maskWr_r <= reset_n && take && hwrite && (haddr[7:0] == 8'h0c);
    if (!reset_n || powerdownPin || !refSettling_r)
      settleCnt_r <= 32'h0;
    else
      settleCnt_r <= settleCnt_r + 32'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_okay; hreadyout && !hresp; endproperty
  property p_pd_clear;
    powerdownPin [*6] |-> sampleWord_r == 12'h0 && !overrangeFlag_r && !sampleValidClock_r;
  endproperty
  property p_settle_hi; $fell(powerdownPin) |-> refSettling_r [*8]; endproperty
  property p_settle_max; settleCnt_r <= SETTLE_CYC + 6; endproperty
  property p_word_chg; $changed(sampleWord_r) |-> !sampleValidClock_r; endproperty
  property p_flag_chg; $changed(overrangeFlag_r) |-> !sampleValidClock_r; endproperty
  property p_hold; $rose(sampleValidClock_r) |=> $stable(sampleWord_r) [*4]; endproperty
  property p_mask_off; maskWr_r && hwdata == 32'h0 |-> ##2 !irq_r; endproperty
  property p_unmapped; take && !hwrite && haddr[7:0] == 8'h14 |=> hrdata == 32'h0; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  a_pd_clear: assert property (p_pd_clear) else $error("outputs live in power-down");
  a_settle_hi: assert property (p_settle_hi) else $error("settle ended early");
  a_settle_max: assert property (p_settle_max) else $error("settle too long");
  a_word_chg: assert property (p_word_chg) else $error("word moved, valid high");
  a_flag_chg: assert property (p_flag_chg) else $error("flag moved, valid high");
  a_hold: assert property (p_hold) else $error("word moved after valid rise");
  a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_pd: cover property (powerdownPin [*6]);
  c_dav: cover property ($rose(sampleValidClock_r));
  c_ovr: cover property ($rose(overrangeFlag_r));
  c_irq: cover property ($rose(irq_r));
endmodule
bind aoi_out_if aoi_out_if_checker #(.SETTLE_CYC(SETTLE_CYC)) u_aoi_out_if_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .powerdownPin(powerdownPin),
  .sampleWord_r(sampleWord_r), .overrangeFlag_r(overrangeFlag_r),
  .sampleValidClock_r(sampleValidClock_r), .refSettling_r(refSettling_r), .irq_r(irq_r),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// file: testbench/aoi_capture.sv
`timescale 1ns/1ps
`default_nettype none
// back-end capture logic on the far side of the sample bus
module aoi_capture
(
  input  wire logic        sampleValidClock,
  input  wire logic [11:0] sampleWord,
  input  wire logic        overrangeFlag,
  output var  logic [12:0] captured
);
  // latch on the valid clock only; it never looks at sys_clk
  always @(posedge sampleValidClock)
    captured <= {overrangeFlag, sampleWord};
endmodule
`default_nettype wire

// file: testbench/pipelined_adc_output_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pipelined_adc_output_interface_bench;
  localparam int SETTLE = 20; // short settle keeps the run brief
  logic sys_clk = 1'b0, reset_n = 1'b0, clockInPos = 1'b1, clockInNeg = 1'b0;
  logic clockKindSelect = 1'b0, formatSelect = 1'b0, powerdownPin = 1'b0;
  logic dutyEqualizerEnable = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [13:0] heldInput = 14'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2; // whole words only
  logic [11:0] sampleWord_r;
  logic        overrangeFlag_r, sampleValidClock_r, refSettling_r, irq_r, hreadyout, hresp;
  logic [12:0] captured;        // partner's latched word
  logic [12:0] hist [0:19];     // expected word of each sample
  int          error_cnt = 0, cmp_count = 0;
  wire         hready = hreadyout; // single slave drives the bus ready
  always #50 sys_clk = ~sys_clk;
  aoi_out_if #(.SETTLE_CYC(SETTLE[16:0])) u_aoi_out_if (
    .sys_clk(sys_clk), .reset_n(reset_n), .clockInPos(clockInPos), .clockInNeg(clockInNeg),
    .clockKindSelect(clockKindSelect), .formatSelect(formatSelect),
    .powerdownPin(powerdownPin), .dutyEqualizerEnable(dutyEqualizerEnable),
    .heldInput(heldInput), .sampleWord_r(sampleWord_r), .overrangeFlag_r(overrangeFlag_r),
    .sampleValidClock_r(sampleValidClock_r), .refSettling_r(refSettling_r), .irq_r(irq_r),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  aoi_capture u_aoi_capture (.sampleValidClock(sampleValidClock_r),
    .sampleWord(sampleWord_r), .overrangeFlag(overrangeFlag_r), .captured(captured));
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; waits on ready, never on a cycle count
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // reference: offset binary, saturated, then recoded
  function logic [12:0] model(input int v, input logic g);
    int d;
    logic [11:0] w;
    d = (v > 2047) ? 4095 : (v < -2048) ? 0 : v + 2048;
    w = d[11:0];
    return {(v > 2047) || (v < -2048), g ? (w ^ (w >> 1)) : (w ^ 12'h800)};
  endfunction
  // single-ended mode drives the negative leg high: it must be ignored
  task setClk(input logic lvl);
    clockInPos <= lvl;
    clockInNeg <= clockKindSelect ? ~lvl : 1'b1;
  endtask
  // flush by power-down, then 20 samples at 24 cycles, 8 high 16 low
  task run(input logic k, input logic g, input logic e, input logic [7:0] t);
    int v;
    ahb(1'b1, 8'h00, {24'h0, t});
    rdchk(8'h00, {24'h0, t});
    @(posedge sys_clk);
    clockKindSelect <= k; formatSelect <= g; dutyEqualizerEnable <= e; powerdownPin <= 1'b1;
    // park the clock high for the new kind, so the first low drive is a real fall
    clockInPos <= 1'b1; clockInNeg <= k ? 1'b0 : 1'b1;
    tick(8);
    #1 chk({18'h0, sampleValidClock_r, overrangeFlag_r, sampleWord_r}, 32'h0);
    rdchk(8'h04, {27'h0, 1'b1, e, 1'b1, g, k});
    @(posedge sys_clk);
    powerdownPin <= 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      v = (i == 3) ? 8191 : (i == 4) ? -8192 : (i == 5) ? 2047 : (i == 6) ? -2048
        : $urandom_range(4900) - 2450;
      hist[i] = model(v, g);
      tick(2);
      heldInput <= v[13:0];
      tick(1);
      setClk(1'b0);
      tick(5);
      #1 if (i >= 9) chk({31'h0, sampleValidClock_r}, {31'h0, !e});
      tick(11);
      setClk(1'b1);
      tick(5);
      #1 if (i >= 8) chk({19'h0, overrangeFlag_r, sampleWord_r}, {19'h0, hist[i-8]});
      if (i >= 9) chk({19'h0, captured}, {19'h0, hist[i-9]});
    end
    rdchk(8'h10, {19'h0, hist[11]});
    rdchk(8'h04, {27'h0, 1'b0, e, 1'b0, g, k});
  endtask
  task end_sim;
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog at roughly ten times the expected run
  initial
  begin
    tick(20000);
    error_cnt++;
    end_sim;
  end
  initial
  begin
    rd = $urandom(32'h4bafca00);
    tick(3);
    reset_n <= 1'b1;
    rdchk(8'h00, 32'h0);
    rdchk(8'h0c, 32'h0);
    run(1'b0, 1'b0, 1'b0, 8'h00);
    run(1'b1, 1'b1, 1'b1, 8'h40);
    run(1'b0, 1'b1, 1'b1, 8'hc0);
    run(1'b1, 1'b0, 1'b0, 8'h20);
    rdchk(8'h08, 32'h3);
    #1 chk({31'h0, irq_r}, 32'h0);
    ahb(1'b1, 8'h0c, 32'h1);
    tick(2);
    #1 chk({31'h0, irq_r}, 32'h1);
    ahb(1'b1, 8'h08, 32'h1);
    tick(2);
    #1 chk({31'h0, irq_r}, 32'h0);
    rdchk(8'h08, 32'h2);
    ahb(1'b1, 8'h0c, 32'h3);
    tick(2);
    #1 chk({31'h0, irq_r}, 32'h1);
    ahb(1'b1, 8'h0c, 32'h0);
    ahb(1'b1, 8'h08, 32'h2);
    rdchk(8'h08, 32'h0);
    rdchk(8'h14, 32'h0);
    ahb(1'b1, 8'h04, 32'h1f);
    rdchk(8'h04, 32'h1);
    end_sim;
  end
endmodule
`default_nettype wire
